// ==== hw/slo_strap_led.sv ====
// Strap capture, per-port control defaults and LED open-drain drivers
`timescale 1ns/1ps

// Functional notes
// - Sample preamble strap at reset; default bit 16.5 for every port.
// - After reset software may read and overwrite both strap-loaded bits.
// - Receive-error pin for port 2 released during reset; pull-down means inactive.
// - Preamble setting ignored when port runs at 100 Mbps.
// - Sample link-hold strap at reset; default bit 0.11 for every port.
// - Link-hold strap high powers down all ports.
// - Receive-error pin for port 6 released during reset; pull-down means inactive.
// - Three LED drivers per port, each source chosen by LED config register.
// - LED drivers released during hardware power-down and reset.
module slo_strap_led #(
    parameter int NP = slo_pkg::NUM_PORTS,
    parameter int NL = slo_pkg::LEDS_PER_PORT
) (
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    input  wire logic                  preambleSelectStrap,
    input  wire logic                  linkHoldStrap,
    input  wire logic                  rxErr2,
    input  wire logic                  rxErr6,
    output logic                       rxErr2Out_r,
    output logic                       rxErr2Oe_r,
    output logic                       rxErr6Out_r,
    output logic                       rxErr6Oe_r,
    input  wire logic                  hwPowerDown,
    input  wire logic                  mgmtWrEn,
    input  wire logic [2:0]            mgmtPort,
    input  wire logic                  mgmtPreData,
    input  wire logic                  mgmtHoldData,
    output logic [NP-1:0]              preambleBit_r,
    output logic [NP-1:0]              powerDownBit_r,
    output logic [NP-1:0]              preambleActive_r,
    input  wire logic [NP-1:0]         portSpeed100,
    input  wire logic [NP-1:0]         portLink,
    input  wire logic [NP-1:0]         portActivity,
    input  wire logic [NP-1:0]         portFullDuplex,
    input  wire logic                  ledCfgWrEn,
    input  wire logic [2:0]            ledCfgPort,
    input  wire logic [NL*4-1:0]       ledCfgData,
    output logic [NP*NL-1:0]           portLedDriverOutput_r,
    output logic [NP*NL-1:0]           portLedDriverOe_r
);
    // ---------------------------------------------
    // Sequencing
    // ---------------------------------------------
    slo_pkg::slo_state_t state_r;
    logic [NP*NL*4-1:0]  ledSel_r;
    logic                inRst;

    // Straps are read one cycle after release, when pins are still released
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= slo_pkg::ST_RESET;
        end else begin
            unique case (state_r)
                slo_pkg::ST_RESET:  state_r <= slo_pkg::ST_SAMPLE;
                slo_pkg::ST_SAMPLE: state_r <= slo_pkg::ST_RUN;
                slo_pkg::ST_RUN:    state_r <= slo_pkg::ST_RUN;
            endcase
        end
    end
    assign inRst = (state_r != slo_pkg::ST_RUN);

    // ---------------------------------------------
    // Shared receive-error pins
    // ---------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rxErr2Out_r <= 1'b0;
            rxErr2Oe_r  <= 1'b0;
            rxErr6Out_r <= 1'b0;
            rxErr6Oe_r  <= 1'b0;
        end else begin
            rxErr2Out_r <= rxErr2;
            rxErr6Out_r <= rxErr6;
            rxErr2Oe_r  <= (state_r == slo_pkg::ST_RUN);
            rxErr6Oe_r  <= (state_r == slo_pkg::ST_RUN);
        end
    end

    // ---------------------------------------------
    // Control bits
    // ---------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            preambleBit_r  <= {NP{slo_pkg::PRE_RST}};
            powerDownBit_r <= {NP{slo_pkg::HOLD_RST}};
        end else if (state_r == slo_pkg::ST_SAMPLE) begin
            preambleBit_r  <= {NP{preambleSelectStrap}};
            powerDownBit_r <= {NP{linkHoldStrap}};
        end else if (state_r == slo_pkg::ST_RUN && mgmtWrEn) begin
            preambleBit_r[mgmtPort]  <= mgmtPreData;
            powerDownBit_r[mgmtPort] <= mgmtHoldData;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            preambleActive_r <= '0;
        end else begin
            preambleActive_r <= preambleBit_r & ~portSpeed100;
        end
    end

    // ---------------------------------------------
    // LED configuration and drivers
    // ---------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ledSel_r <= '0;
        end else if (ledCfgWrEn && !inRst) begin
            ledSel_r[ledCfgPort*NL*4 +: NL*4] <= ledCfgData;
        end
    end

    function automatic logic ledOn(input logic [3:0] sel, input logic lk,
                                   input logic ac, input logic sp, input logic fd);
        logic r;
        r = 1'b0;
        case (sel)
            slo_pkg::SEL_LINK: r = lk;
            slo_pkg::SEL_ACT:  r = ac;
            slo_pkg::SEL_SPD:  r = sp;
            slo_pkg::SEL_DUP:  r = fd;
            slo_pkg::SEL_ON:   r = 1'b1;
            default:           r = 1'b0;
        endcase
        return r;
    endfunction

    // Output data stays low; the enable alone lights the LED
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            portLedDriverOutput_r <= '0;
            portLedDriverOe_r     <= '0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                for (int l = 0; l < NL; l++) begin
                    portLedDriverOutput_r[p*NL+l] <= 1'b0;
                    portLedDriverOe_r[p*NL+l] <= !inRst && !hwPowerDown
                        && !powerDownBit_r[p]
                        && ledOn(ledSel_r[(p*NL+l)*4 +: 4], portLink[p],
                                 portActivity[p], portSpeed100[p], portFullDuplex[p]);
                end
            end
        end
    end

    // ---------------------------------------------
    // Check helpers
    // ---------------------------------------------
    // Drivers forced on or off by their select; kept apart from the driver logic
    // so the checks do not reuse the decode they are meant to guard
    logic [NP*NL-1:0] forcedOn;
    logic [NP*NL-1:0] forcedOff;

    always_comb begin
        forcedOn  = '0;
        forcedOff = '0;
        for (int i = 0; i < NP*NL; i++) begin
            forcedOn[i]  = (ledSel_r[i*4 +: 4] == slo_pkg::SEL_ON) && !powerDownBit_r[i/NL];
            forcedOff[i] = (ledSel_r[i*4 +: 4] == slo_pkg::SEL_OFF);
        end
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    strap_pre_a: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == slo_pkg::ST_SAMPLE |=> preambleBit_r == {NP{$past(preambleSelectStrap)}})
        else $error("preamble default not loaded");
    strap_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == slo_pkg::ST_SAMPLE |=> powerDownBit_r == {NP{$past(linkHoldStrap)}})
        else $error("link-hold default not loaded");
    sw_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == slo_pkg::ST_RUN && mgmtWrEn
        |=> preambleBit_r[$past(mgmtPort)] == $past(mgmtPreData))
        else $error("software write lost");
    rxerr_hiz_a: assert property (@(posedge mclk) disable iff (!rst_b)
        inRst |=> !rxErr2Oe_r && !rxErr6Oe_r)
        else $error("receive-error pin driven in reset");
    rx6_rel_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(rxErr6Oe_r) |-> $past(state_r) == slo_pkg::ST_RUN)
        else $error("port 6 pin enabled early");
    speed_mask_a: assert property (@(posedge mclk) disable iff (!rst_b)
        preambleActive_r == ($past(preambleBit_r) & ~$past(portSpeed100)))
        else $error("preamble acted at 100 Mbps");
    pd_dark_a: assert property (@(posedge mclk) disable iff (!rst_b)
        powerDownBit_r == '1 |=> portLedDriverOe_r == '0)
        else $error("LED lit while powered down");
    led_hiz_a: assert property (@(posedge mclk) disable iff (!rst_b)
        hwPowerDown |=> portLedDriverOe_r == '0)
        else $error("LED driven in power-down");
    led_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
        portLedDriverOutput_r == '0)
        else $error("LED data not low");
    sw_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        state_r == slo_pkg::ST_RUN && mgmtWrEn
        |=> powerDownBit_r[$past(mgmtPort)] == $past(mgmtHoldData))
        else $error("software power-down write lost");
    rx2_rel_a: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(rxErr2Oe_r) |-> $past(state_r) == slo_pkg::ST_RUN)
        else $error("port 2 pin enabled early");
    rx_data_a: assert property (@(posedge mclk) disable iff (!rst_b)
        rxErr2Oe_r && rxErr6Oe_r
        |-> rxErr2Out_r == $past(rxErr2) && rxErr6Out_r == $past(rxErr6))
        else $error("receive-error data not passed to pins");
    led_rst_a: assert property (@(posedge mclk) disable iff (!rst_b)
        inRst |=> portLedDriverOe_r == '0)
        else $error("LED driven during start-up");
    pd_port_a: assert property (@(posedge mclk) disable iff (!rst_b)
        powerDownBit_r[0] |=> portLedDriverOe_r[NL-1:0] == '0)
        else $error("port 0 LED lit while powered down");
    led_on_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !inRst && !hwPowerDown |=> (portLedDriverOe_r & $past(forcedOn)) == $past(forcedOn))
        else $error("forced-on LED stayed dark");
    led_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
        (portLedDriverOe_r & $past(forcedOff)) == '0)
        else $error("switched-off LED lit");

    // ---------------------------------------------
    // Start-up order
    // ---------------------------------------------
    // Straps are taken while both shared pins are still released; the pins
    // come back only after the run state is reached
    sequence seqSampling;
        state_r == slo_pkg::ST_SAMPLE;
    endsequence
    sequence seqRunning;
        state_r == slo_pkg::ST_RUN;
    endsequence
    sequence seqPinsOn;
        rxErr2Oe_r && rxErr6Oe_r;
    endsequence
    boot_order_a: assert property (@(posedge mclk) disable iff (!rst_b)
        seqSampling |=> seqRunning ##1 seqPinsOn)
        else $error("start-up steps out of order");
endmodule

// ==== inc/slo_pkg.sv ====
// Shared constants for the strap latch and LED output block
package slo_pkg;
    localparam int NUM_PORTS     = 8;
    localparam int LEDS_PER_PORT = 3;
    localparam int LED_SEL_W     = 4;
    localparam int PRE_BIT_POS   = 5;   // Preamble control bit in extended control word
    localparam int HOLD_BIT_POS  = 11;  // Power-down bit in basic control word
    localparam int LED_CFG_ADDR  = 20;
    localparam logic PRE_RST     = 1'b0;
    localparam logic HOLD_RST    = 1'b0;
    localparam logic [3:0] SEL_OFF  = 4'h0;
    localparam logic [3:0] SEL_LINK = 4'h1;
    localparam logic [3:0] SEL_ACT  = 4'h2;
    localparam logic [3:0] SEL_SPD  = 4'h3;
    localparam logic [3:0] SEL_DUP  = 4'h4;
    localparam logic [3:0] SEL_ON   = 4'h5;
    typedef enum logic [1:0] {ST_RESET, ST_SAMPLE, ST_RUN} slo_state_t;
endpackage

// ==== dv/slo_board.sv ====
// Board model: strap resistors on the shared pins and the LED lamps
`timescale 1ns/1ps
module slo_board (
    input  wire logic        pullPre,
    input  wire logic        pullHold,
    input  wire logic        out2,
    input  wire logic        oe2,
    input  wire logic        out6,
    input  wire logic        oe6,
    input  wire logic [23:0] ledOut,
    input  wire logic [23:0] ledOe,
    output logic             preStrap,
    output logic             holdStrap,
    output logic [23:0]      lit
);
    // Released pin settles to its resistor, pull-down unless fitted
    assign preStrap  = oe2 ? out2 : pullPre;
    assign holdStrap = oe6 ? out6 : pullHold;
    // Only a driven low lights a lamp
    assign lit = ledOe & ~ledOut;
endmodule

// ==== dv/test_slo_strap_led.sv ====
// Self-checking bench for the strap latch and LED output block
`timescale 1ns/1ps
module test_slo_strap_led;
    logic mclk = 0, rst_b = 0, pp = 0, ph = 0, e2 = 0, e6 = 0, hpd = 0, wEn = 0, wA = 0, wB = 0;
    logic cEn = 0, o2, oe2, o6, oe6, preS, holdS;
    logic [2:0] wP = 0, cP = 0;
    logic [11:0] cD = 0;
    logic [7:0] spd = 0, lnk = 0, act = 0, fd = 0, preB, pdB, preA, mPre, mHold;
    logic [23:0] ledO, ledOe, lit;
    logic [3:0] mSel [24];
    logic [31:0] rs = 68356;
    int errors = 0, samples_checked = 0;
    slo_strap_led dut (.mclk(mclk), .rst_b(rst_b), .preambleSelectStrap(preS),
        .linkHoldStrap(holdS), .rxErr2(e2), .rxErr6(e6), .rxErr2Out_r(o2), .rxErr2Oe_r(oe2),
        .rxErr6Out_r(o6), .rxErr6Oe_r(oe6), .hwPowerDown(hpd), .mgmtWrEn(wEn), .mgmtPort(wP),
        .mgmtPreData(wA), .mgmtHoldData(wB), .preambleBit_r(preB), .powerDownBit_r(pdB),
        .preambleActive_r(preA), .portSpeed100(spd), .portLink(lnk), .portActivity(act),
        .portFullDuplex(fd), .ledCfgWrEn(cEn), .ledCfgPort(cP), .ledCfgData(cD),
        .portLedDriverOutput_r(ledO), .portLedDriverOe_r(ledOe));
    slo_board brd (.pullPre(pp), .pullHold(ph), .out2(o2), .oe2(oe2), .out6(o6), .oe6(oe6),
        .ledOut(ledO), .ledOe(ledOe), .preStrap(preS), .holdStrap(holdS), .lit(lit));
    initial forever #25 mclk = ~mclk;
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    // Expected lamp pattern; power-down of a port or the chip darkens it
    function automatic logic [23:0] ledExp();
        logic [23:0] v;
        logic s;
        for (int q = 0; q < 24; q++) begin
            case (mSel[q])
                1: s = lnk[q/3];
                2: s = act[q/3];
                3: s = spd[q/3];
                4: s = fd[q/3];
                5: s = 1'b1;
                default: s = 1'b0;
            endcase
            v[q] = s & ~mHold[q/3] & ~hpd;
        end
        return v;
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic end_sim();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic resetRun(input logic a, input logic b);
        @(posedge mclk) rst_b <= 0;
        pp <= a;
        ph <= b;
        hpd <= 0;
        repeat (4) @(posedge mclk);
        @(negedge mclk) chk("rxOe", {oe2, oe6}, 0);
        chk("ledOe", ledOe, 0);
        @(posedge mclk) rst_b <= 1;
        mPre = {8{a}};
        mHold = {8{b}};
        foreach (mSel[q]) mSel[q] = 0;
        repeat (3) @(posedge mclk);
        @(negedge mclk) chk("pre", preB, mPre);
        chk("hold", pdB, mHold);
    endtask
    task automatic wr(input logic [2:0] p, input logic [31:0] r);
        @(posedge mclk) wEn <= 1;
        {wP, wA, wB, e2, e6} <= {p, r[3:0]};
        @(posedge mclk) wEn <= 0;
        mPre[p] = r[3];
        mHold[p] = r[2];
        @(negedge mclk) chk("pre", preB, mPre);
        chk("hold", pdB, mHold);
        chk("rx", {oe2, o2, oe6, o6}, {1'b1, r[1], 1'b1, r[0]});
        @(negedge mclk) chk("preAct", preA, mPre & ~spd);
    endtask
    task automatic led(input int i, input logic [2:0] p);
        logic [31:0] r;
        r = xs();
        @(posedge mclk) cEn <= 1;
        {cP, cD, hpd} <= {p, 4'(i + 2), 4'(i + 1), 4'(i), i == 7};
        {spd, lnk, act, fd} <= r;
        @(posedge mclk) cEn <= 0;
        for (int l = 0; l < 3; l++) mSel[p*3+l] = 4'(i + l);
        repeat (2) @(posedge mclk);
        @(negedge mclk) chk("ledOe", ledOe, ledExp());
        chk("lit", lit, ledExp());
    endtask
    initial begin
        for (int k = 0; k < 4; k++) begin
            resetRun(k[0], k[1]);
            for (int j = 0; j < 2; j++) begin
                for (int i = 0; i < 8; i++) led(i, 3'(i + j));
                for (int p = 0; p < 8; p++) wr(3'(p), xs());
            end
        end
        end_sim();
    end
    initial begin
        #200000;
        errors++;
        end_sim();
    end
endmodule
